//--- core/lsi_status_intr.sv
// How it works
// - each monitored event or present condition sets its bit in one of nine status registers.
// - status and receive information bits latch and stay at one until read.
// - a read clears the bits armed by the mask, and only a new event or a source still present sets them again.
// - blue, yellow, carrier-loss and sync-loss bits stay set after a read while the alarm lasts.
// - each masked bit copies its latest latched value into the readable copy.
// - each unmasked bit keeps its previous readable value.
// - only status one, status two and the hdlc status register can pull the interrupt.
// - every source of those three registers has its own bit in its mask register.
// - an enabled alarm pulls the interrupt low on each change, both rising and falling.
// - reading the alarm bit releases the interrupt even if the alarm persists.
// - an enabled event pulls the interrupt low until its bit is read.
`include "lsi_defs.svh"
`default_nettype none

module lsi_status_intr #(
   parameter int NUM_REGS = `LSI_NUM_REGS,
   parameter logic [7:0] STATUS_ONE_ALARMS = `LSI_STATUS_ONE_ALARMS
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] host_sel,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [7:0] host_wdata,
   output logic [7:0] host_rdata,
   input wire logic [7:0] irq_mask_one,
   input wire logic [7:0] irq_mask_two,
   input wire logic [7:0] hdlc_irq_mask,
   input wire logic [NUM_REGS-1:0][7:0] status_src,
   output logic [NUM_REGS-1:0][7:0] status_latched,
   output logic int_n
);

   // ----------------------------------------
   // source synchronisation
   // ----------------------------------------
   // events arrive with no relation to the host clock
   logic [NUM_REGS*8-1:0] src_flat;
   logic [NUM_REGS*8-1:0] src_sync_flat;
   logic [NUM_REGS-1:0][7:0] src_s;

   assign src_flat = status_src;
   assign src_s = src_sync_flat;

   lsi_sync #(
      .WIDTH(NUM_REGS * 8)
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .din(src_flat),
      .dout(src_sync_flat)
   );

   // ----------------------------------------
   // host access decode
   // ----------------------------------------
   logic [NUM_REGS-1:0] wr_hit;
   logic [NUM_REGS-1:0] rd_hit;

   always_comb begin
      wr_hit = '0;
      for (int k = 0; k < NUM_REGS; k++) begin
         if (host_sel == 4'(k)) begin
            wr_hit[k] = host_wr;
         end
      end
   end

   // a select above the last register hits nothing, so it arms and clears nothing
   always_comb begin
      rd_hit = '0;
      for (int k = 0; k < NUM_REGS; k++) begin
         if (host_sel == 4'(k)) begin
            rd_hit[k] = host_rd;
         end
      end
   end

   // ----------------------------------------
   // per-register latch, view and pending state
   // ----------------------------------------
   logic [NUM_REGS-1:0][7:0] lat;
   logic [NUM_REGS-1:0][7:0] shown_all;
   logic [NUM_REGS-1:0][7:0] req;

   genvar g;
   generate
      for (g = 0; g < NUM_REGS; g++) begin : g_reg
         localparam logic [7:0] ALARMS = (g == `LSI_SEL_STATUS_ONE) ?
                                         STATUS_ONE_ALARMS : `LSI_NO_ALARMS;
         localparam bit CAN_IRQ = (g == `LSI_SEL_STATUS_ONE) ||
                                  (g == `LSI_SEL_STATUS_TWO) ||
                                  (g == `LSI_SEL_HDLC_STATUS);
         lsi_acc_if acc ();
         logic [7:0] clr;
         logic [7:0] prev;
         logic [7:0] apend;
         logic [7:0] chg;
         logic [7:0] mask;
         logic [7:0] next_lat;
         logic [7:0] next_apend;
         logic [7:0] alarm_lvl;
         logic [7:0] alarm_req;
         logic [7:0] event_req;

         assign acc.wr = wr_hit[g];
         assign acc.rd = rd_hit[g];
         assign acc.wdata = host_wdata;
         assign acc.lat = lat[g];
         assign shown_all[g] = acc.shown;

         lsi_view u_view (
            .clk(clk),
            .rst_n(rst_n),
            .acc(acc)
         );

         // ----------------------------------------
         // latched bits
         // ----------------------------------------
         // read clears armed bits
         assign clr = rd_hit[g] ? acc.armed : 8'h00;

         // present alarm re-sets, set beats clear
         assign next_lat = (lat[g] & ~clr) | src_s[g];

         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               lat[g] <= `LSI_RESET_BYTE;
            end else begin
               lat[g] <= next_lat;
            end
         end

         // ----------------------------------------
         // alarm change detection
         // ----------------------------------------
         assign alarm_lvl = src_s[g] & ALARMS;

         // previous alarm level
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               prev <= `LSI_RESET_BYTE;
            end else begin
               prev <= alarm_lvl;
            end
         end

         assign chg = alarm_lvl ^ prev;
         // alarm pending cleared by its read
         assign next_apend = (apend & ~clr) | chg;

         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               apend <= `LSI_RESET_BYTE;
            end else begin
               apend <= next_apend;
            end
         end

         // ----------------------------------------
         // interrupt request
         // ----------------------------------------
         // per-source mask select
         always_comb begin
            mask = 8'h00;
            if (g == `LSI_SEL_STATUS_ONE) begin
               mask = irq_mask_one;
            end else if (g == `LSI_SEL_STATUS_TWO) begin
               mask = irq_mask_two;
            end else if (g == `LSI_SEL_HDLC_STATUS) begin
               mask = hdlc_irq_mask;
            end
         end

         assign alarm_req = apend & mask;

         // event pends while latched
         // alarm bits stay out: a lasting alarm must not hold the pin low
         assign event_req = lat[g] & ~ALARMS & mask;

         assign req[g] = CAN_IRQ ? (alarm_req | event_req) : 8'h00;
      end
   endgenerate

   // ----------------------------------------
   // read data
   // ----------------------------------------
   logic [7:0] sel_shown;
   logic sel_valid;
   logic [7:0] next_host_rdata;

   // out-of-range selects read as zero
   always_comb begin
      sel_shown = `LSI_RESET_BYTE;
      sel_valid = 1'b0;
      for (int k = 0; k < NUM_REGS; k++) begin
         if (host_sel == 4'(k)) begin
            sel_shown = shown_all[k];
            sel_valid = 1'b1;
         end
      end
   end

   // read data stands until the next read
   always_comb begin
      next_host_rdata = host_rdata;
      if (host_rd && sel_valid) begin
         next_host_rdata = sel_shown;
      end else if (host_rd) begin
         next_host_rdata = `LSI_RESET_BYTE;
      end
   end

   // read returns the copy taken at the mask write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         host_rdata <= `LSI_RESET_BYTE;
      end else begin
         host_rdata <= next_host_rdata;
      end
   end

   // latched state, registered one cycle behind lat, for observation
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_latched <= '0;
      end else begin
         status_latched <= lat;
      end
   end

   // ----------------------------------------
   // interrupt output
   // ----------------------------------------
   logic [NUM_REGS-1:0] reg_pending;
   logic any_pending;
   logic next_int_n;

   // one summary bit per register keeps the final or narrow
   always_comb begin
      reg_pending = '0;
      for (int k = 0; k < NUM_REGS; k++) begin
         reg_pending[k] = |req[k];
      end
   end

   // or of all enabled pending sources
   always_comb begin
      any_pending = |reg_pending;
      next_int_n = ~any_pending;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         int_n <= `LSI_RESET_INT_N;
      end else begin
         int_n <= next_int_n;
      end
   end

endmodule

`default_nettype wire

//--- core/lsi_defs.svh
`ifndef LSI_DEFS_SVH
`define LSI_DEFS_SVH

// ----------------------------------------
// register selects on the host port
// ----------------------------------------
`define LSI_SEL_STATUS_ONE 4'h0
`define LSI_SEL_STATUS_TWO 4'h1
`define LSI_SEL_INFO_ONE 4'h2
`define LSI_SEL_INFO_TWO 4'h3
`define LSI_SEL_INFO_THREE 4'h4
`define LSI_SEL_HDLC_STATUS 4'h5
`define LSI_SEL_HDLC_AUX_ONE 4'h6
`define LSI_SEL_HDLC_AUX_TWO 4'h7
`define LSI_SEL_HDLC_AUX_THREE 4'h8
`define LSI_NUM_REGS 9

// ----------------------------------------
// field layout and reset values
// ----------------------------------------
`define LSI_REG_WIDTH 8
// blue, yellow, carrier-loss, sync-loss alarm levels in status one
`define LSI_ALARM_BIT_YELLOW 3
`define LSI_ALARM_BIT_CARRIER 2
`define LSI_ALARM_BIT_BLUE 1
`define LSI_ALARM_BIT_SYNC 0
`define LSI_STATUS_ONE_ALARMS 8'h0f
`define LSI_NO_ALARMS 8'h00
`define LSI_RESET_BYTE 8'h00
`define LSI_RESET_INT_N 1'b1

// ----------------------------------------
// timing
// ----------------------------------------
`define LSI_SYNC_STAGES 2

`endif

//--- core/lsi_pkg.sv
`default_nettype none

package lsi_pkg;
   typedef logic [7:0] lsi_byte_t;
   // phase of a register's masked read sequence
   typedef enum logic [1:0] {
      lsi_idle,
      lsi_armed,
      lsi_read
   } lsi_phase_t;
endpackage

`default_nettype wire

//--- core/lsi_acc_if.sv
`default_nettype none

interface lsi_acc_if;
   logic wr;
   logic rd;
   lsi_pkg::lsi_byte_t wdata;
   lsi_pkg::lsi_byte_t lat;
   lsi_pkg::lsi_byte_t shown;
   lsi_pkg::lsi_byte_t armed;

   modport ctl (
      output wr,
      output rd,
      output wdata,
      output lat,
      input shown,
      input armed
   );

   modport view (
      input wr,
      input rd,
      input wdata,
      input lat,
      output shown,
      output armed
   );
endinterface

`default_nettype wire

//--- core/lsi_sync.sv
`include "lsi_defs.svh"
`default_nettype none

module lsi_sync #(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   // first stage is read by the second stage only
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         dout <= '0;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule

`default_nettype wire

//--- core/lsi_view.sv
`include "lsi_defs.svh"
`default_nettype none

module lsi_view (
   input wire logic clk,
   input wire logic rst_n,
   lsi_acc_if.view acc
);
   lsi_pkg::lsi_byte_t shown;
   lsi_pkg::lsi_byte_t armed;

   // --------------------------------
   // readable copy
   // --------------------------------
   // masked copy refresh
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shown <= `LSI_RESET_BYTE;
      end else if (acc.wr) begin
         shown <= (shown & ~acc.wdata) | (acc.lat & acc.wdata);
      end
   end

   // --------------------------------
   // bits armed for clearing
   // --------------------------------
   // a write wins over a read in the same cycle; the read still clears the bits armed before the write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         armed <= `LSI_RESET_BYTE;
      end else if (acc.wr) begin
         armed <= acc.wdata;
      end else if (acc.rd) begin
         armed <= `LSI_RESET_BYTE;
      end
   end

   assign acc.shown = shown;
   assign acc.armed = armed;
endmodule

`default_nettype wire

//--- verif/lsi_status_intr_properties.sv
`default_nettype none

module lsi_status_intr_properties #(
   parameter int NUM_REGS = 9
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] host_sel,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [7:0] host_wdata,
   input wire logic [7:0] host_rdata,
   input wire logic [7:0] irq_mask_one,
   input wire logic [7:0] irq_mask_two,
   input wire logic [7:0] hdlc_irq_mask,
   input wire logic [NUM_REGS-1:0][7:0] status_src,
   input wire logic [NUM_REGS-1:0][7:0] status_latched,
   input wire logic int_n
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   AST_EVENT_SETS: assert property (status_src[2][0] [*6] |-> status_latched[2][0])
      else $error("event bit did not latch");
   AST_LATCH_HOLDS: assert property ($fell(status_latched[2][7]) |->
      $past(host_rd, 2) && $past(host_sel, 2) == 4'h2) else $error("bit fell without a read");
   AST_ALARM_STAYS: assert property (status_src[0][1] [*6] |-> status_latched[0][1])
      else $error("alarm bit cleared while alarm present");
   AST_FULL_MASK: assert property (host_wr && host_sel == 4'h2 && host_wdata == 8'hff
      ##1 host_rd && !host_wr && host_sel == 4'h2
      |=> (host_rdata & $past(status_latched[2])) == $past(status_latched[2]))
      else $error("masked bit not copied to read data");
   AST_ZERO_MASK: assert property (host_wr && host_wdata == 8'h00
      ##1 host_rd && !host_wr |=> $stable(host_rdata)) else $error("zero mask changed read data");
   AST_RDATA_HOLDS: assert property (!host_rd |=> $stable(host_rdata))
      else $error("read data moved without a read");
   AST_NO_MASK_NO_INT: assert property ((irq_mask_one == 8'h00 && irq_mask_two == 8'h00
      && hdlc_irq_mask == 8'h00) [*2] |-> int_n) else $error("interrupt with all masks off");
   AST_EVENT_INT: assert property ((status_latched[1][0] && irq_mask_two[0]) [*2] |-> !int_n)
      else $error("enabled event did not pull interrupt");
endmodule

bind lsi_status_intr lsi_status_intr_properties #(.NUM_REGS(NUM_REGS)) u_props (
   .clk(clk), .rst_n(rst_n), .host_sel(host_sel), .host_wr(host_wr), .host_rd(host_rd),
   .host_wdata(host_wdata), .host_rdata(host_rdata), .irq_mask_one(irq_mask_one),
   .irq_mask_two(irq_mask_two), .hdlc_irq_mask(hdlc_irq_mask), .status_src(status_src),
   .status_latched(status_latched), .int_n(int_n));

`default_nettype wire

//--- verif/lsi_host.sv
`default_nettype none

module lsi_host (
   input wire logic clk,
   output logic [3:0] host_sel,
   output logic host_wr,
   output logic host_rd,
   output logic [7:0] host_wdata,
   input wire logic [7:0] host_rdata
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      host_sel = 4'h0;
      host_wr = 1'b0;
      host_rd = 1'b0;
      host_wdata = 8'h00;
   end

   task poll(input logic [3:0] sel, input logic [7:0] mask, output logic [7:0] val);
      @(posedge clk);
      host_sel <= sel;
      host_wr <= 1'b1;
      host_wdata <= mask;
      @(posedge clk);
      host_wr <= 1'b0;
      host_wdata <= ~mask;
      host_rd <= 1'b1;
      @(posedge clk);
      host_rd <= 1'b0;
      #1;
      val = host_rdata;
      @(posedge clk);
      host_wr <= 1'b1;
      host_wdata <= val & mask;
      @(posedge clk);
      host_wr <= 1'b0;
      host_wdata <= ~(val & mask);
   endtask
endmodule

`default_nettype wire

//--- verif/lsi_status_intr_test.sv
`default_nettype none

module lsi_status_intr_test;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [3:0] sel; logic [7:0] pat; logic irq;} lsi_row_t;
   logic clk, rst_n, host_wr, host_rd, int_n;
   logic [3:0] host_sel;
   logic [7:0] host_wdata, host_rdata, mask_one, mask_two, mask_hdlc, v;
   logic [8:0][7:0] src, latched;
   int miscompares = 0;
   int n_tests = 0;
   lsi_row_t rows [9] = '{'{4'h0, 8'h30, 1'b1}, '{4'h1, 8'h41, 1'b1}, '{4'h2, 8'h81, 1'b0},
      '{4'h3, 8'h24, 1'b0}, '{4'h4, 8'h18, 1'b0}, '{4'h5, 8'h42, 1'b1},
      '{4'h6, 8'h11, 1'b0}, '{4'h7, 8'h88, 1'b0}, '{4'h8, 8'h05, 1'b0}};

   lsi_status_intr dut (.clk(clk), .rst_n(rst_n), .host_sel(host_sel), .host_wr(host_wr),
      .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
      .irq_mask_one(mask_one), .irq_mask_two(mask_two), .hdlc_irq_mask(mask_hdlc),
      .status_src(src), .status_latched(latched), .int_n(int_n));
   lsi_host host (.clk(clk), .host_sel(host_sel), .host_wr(host_wr), .host_rd(host_rd),
      .host_wdata(host_wdata), .host_rdata(host_rdata));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task chk1(input string name, input logic exp, input logic got);
      chk8(name, {7'h00, exp}, {7'h00, got});
   endtask

   task end_of_test;
      $display("comparisons %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // bounded wait, a timeout ends the run
   task wait_int(input logic exp);
      for (int i = 0; i < 12 && int_n !== exp; i++) @(posedge clk) #1;
      chk1("int_n", exp, int_n);
      if (int_n !== exp) end_of_test();
   endtask

   task pulse(input int sel, input logic [7:0] pat);
      @(posedge clk);
      src[sel] <= pat;
      repeat (7) @(posedge clk);
      src[sel] <= 8'h00;
      repeat (6) @(posedge clk);
      #1;
   endtask

   initial begin
      rst_n = 1'b0;
      {mask_one, mask_two, mask_hdlc} = '0;
      src = '0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk8("reset rdata", 8'h00, host_rdata);
      chk1("reset int_n", 1'b1, int_n);
      repeat (3) @(posedge clk);
      {mask_one, mask_two, mask_hdlc} <= {3{8'hff}};
      foreach (rows[i]) begin
         pulse(rows[i].sel, rows[i].pat);
         chk1("int_n", ~rows[i].irq, int_n);
         host.poll(rows[i].sel, 8'hff, v);
         chk8("rdata", rows[i].pat, v);
         wait_int(1'b1);
         host.poll(rows[i].sel, 8'hff, v);
         chk8("rdata again", 8'h00, v);
      end
      host.poll(4'h2, 8'h00, v);
      chk8("zero mask", 8'h00, v);
      pulse(1, 8'h81);
      host.poll(4'h1, 8'h01, v);
      chk8("mask low", 8'h01, v);
      chk1("int_n other", 1'b0, int_n);
      // the write-back of 8'h01 refreshed bit 0 with its cleared value
      host.poll(4'h1, 8'h80, v);
      chk8("held bit", 8'h80, v);
      wait_int(1'b1);
      mask_two <= 8'h00;
      pulse(1, 8'h01);
      chk1("masked int_n", 1'b1, int_n);
      host.poll(4'h1, 8'hff, v);
      mask_two <= 8'hff;
      @(posedge clk);
      src[0] <= 8'h02;
      wait_int(1'b0);
      host.poll(4'h0, 8'h02, v);
      wait_int(1'b1);
      host.poll(4'h0, 8'h02, v);
      chk8("alarm bit", 8'h02, v);
      src[0] <= 8'h00;
      wait_int(1'b0);
      host.poll(4'h0, 8'h02, v);
      wait_int(1'b1);
      host.poll(4'h9, 8'hff, v);
      chk8("bad select", 8'h00, v);
      end_of_test();
   end
endmodule

`default_nettype wire
